/* File: logic/lst_pkg.sv */
// package: register map, field layout and pattern tables for the loss block
package lst_pkg;

  // ************************************************************
  // register indexes (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] LST_IDX_OVERLAY  = 6'h0A;
  localparam logic [5:0] LST_IDX_PATCTRL  = 6'h0B;
  localparam logic [5:0] LST_IDX_FAST_ERR = 6'h20;
  localparam logic [5:0] LST_IDX_SLOW_ERR = 6'h21;
  localparam logic [5:0] LST_IDX_IRQ_STAT = 6'h22;
  localparam logic [5:0] LST_IDX_IRQ_MASK = 6'h23;
  localparam logic [5:0] LST_IDX_MODE     = 6'h24;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [15:0] LST_OVERLAY_RST = 16'h4000;
  localparam logic [15:0] LST_PATCTRL_RST = 16'h0D10;
  localparam int LST_POS_PLL_EN   = 12;
  localparam int LST_POS_SYNC_LO  = 8;
  localparam int LST_POS_CODE_LO  = 4;
  localparam int LST_POS_SIG_LO   = 0;
  localparam int LST_POS_FGEN     = 13;
  localparam int LST_POS_FCHK     = 12;
  localparam int LST_POS_SSEL_HI  = 11;
  localparam int LST_POS_FSEL_LO  = 8;
  localparam int LST_POS_SGEN     = 7;
  localparam int LST_POS_SCHK     = 6;
  localparam int LST_POS_SSEL_LO  = 4;
  localparam int LST_IRQ_W        = 3;
  localparam int LST_IRQ_PIN      = 0;
  localparam int LST_IRQ_FERR     = 1;
  localparam int LST_IRQ_SERR     = 2;
  localparam logic [15:0] LST_ERR_MAX = 16'hFFFF;
  localparam logic [4:0]  LST_CHK_FILL = 5'h1F;   // history fill time

  // ************************************************************
  // operating modes and pattern codes
  // ************************************************************
  typedef enum logic [1:0] {
    LST_MODE_1GKX = 2'h0,
    LST_MODE_10G  = 2'h1,
    LST_MODE_10GKR = 2'h2
  } lst_mode_t;

  localparam logic [2:0] LST_PAT_HF    = 3'h0;
  localparam logic [2:0] LST_PAT_LF    = 3'h1;
  localparam logic [2:0] LST_PAT_MF    = 3'h2;
  localparam logic [2:0] LST_PAT_CRL   = 3'h3;
  localparam logic [2:0] LST_PAT_CRS   = 3'h4;
  localparam logic [2:0] LST_PAT_PRBS7 = 3'h5;
  localparam logic [2:0] LST_PAT_PRBS23 = 3'h6;
  localparam logic [2:0] LST_PAT_PRBS31 = 3'h7;

  // sampled lane conditions, one bit per lane plus a single pll unlock bit
  typedef struct packed {
    logic       pll_unlock;
    logic [3:0] sync_loss;
    logic [3:0] bad_code;
    logic [3:0] signal_loss;
  } lst_cond_t;

  // periodic pattern word, sent from bit 0 upward
  function automatic logic [19:0] lst_pat_word(input logic [2:0] sel);
    case (sel)
      LST_PAT_HF:  lst_pat_word = 20'hAAAAA;
      LST_PAT_LF:  lst_pat_word = 20'hF83E0;
      LST_PAT_MF:  lst_pat_word = 20'h0A0FA;
      LST_PAT_CRL: lst_pat_word = 20'h3C3CF;
      default:     lst_pat_word = 20'hC3C33;
    endcase
  endfunction : lst_pat_word

  // period of a periodic pattern in bits
  function automatic logic [4:0] lst_pat_len(input logic [2:0] sel);
    case (sel)
      LST_PAT_HF: lst_pat_len = 5'h02;
      LST_PAT_LF: lst_pat_len = 5'h0A;
      default:    lst_pat_len = 5'h14;
    endcase
  endfunction : lst_pat_len

  // feedback bit of the selected prbs polynomial over a history word
  function automatic logic lst_prbs_fb(input logic [2:0]  sel,
                                       input logic [30:0] h);
    case (sel)
      LST_PAT_PRBS7:  lst_prbs_fb = h[6] ^ h[5];
      LST_PAT_PRBS23: lst_prbs_fb = h[22] ^ h[17];
      default:        lst_prbs_fb = h[30] ^ h[27];
    endcase
  endfunction : lst_prbs_fb

endpackage : lst_pkg

/* File: logic/lst_sync.sv */
// three-stage input synchroniser that accepts a change once stages agree
`timescale 1ns/1ns
module lst_sync #(
  parameter int W = 13
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // asynchronous levels in, settled levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // shift chain; only the second stage reads the first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // take a bit only while the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_out <= '0;
    end else begin
      sync_out <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & sync_out);
    end
  end

endmodule : lst_sync

/* File: logic/lst_pattern.sv */
// serial test pattern generator and self-aligning verifier for one side
`timescale 1ns/1ns
module lst_pattern (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       gen_en,
  input  wire logic       chk_en,
  input  wire logic [2:0] sel,
  input  wire logic       sel_ok,
  // serial data
  output logic            pat_bit,
  input  wire logic       rx_bit,
  output logic            err_pulse
);

  logic [30:0] lfsr_r;
  logic [4:0]  idx_r;
  logic [30:0] hist_r;
  logic [4:0]  fill_r;
  logic        prbs;
  logic [4:0]  len;
  logic        expect_bit;
  logic [19:0] word;

  assign prbs = sel[2] & (sel[1] | sel[0]);
  assign len  = lst_pkg::lst_pat_len(sel);
  assign word = lst_pkg::lst_pat_word(sel);

  // next transmitted bit: lfsr feedback or periodic word bit
  always_comb begin
    if (!gen_en || !sel_ok) begin
      pat_bit = 1'b0;
    end else if (prbs) begin
      pat_bit = lst_pkg::lst_prbs_fb(sel, lfsr_r);
    end else begin
      pat_bit = word[idx_r];
    end
  end

  // generator state advances only while generating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_r <= '1;
      idx_r  <= '0;
    end else if (gen_en && sel_ok) begin
      lfsr_r <= {lfsr_r[29:0], pat_bit};
      idx_r  <= (idx_r >= len - 5'h01) ? 5'h00 : idx_r + 5'h01;
    end else begin
      lfsr_r <= '1;
      idx_r  <= '0;
    end
  end

  // expected bit comes from the received history itself
  assign expect_bit = prbs ? lst_pkg::lst_prbs_fb(sel, hist_r)
                           : hist_r[len - 5'h01];

  // history and fill counter; no errors until the history is full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_r    <= '0;
      fill_r    <= '0;
      err_pulse <= 1'b0;
    end else if (chk_en && sel_ok) begin
      hist_r    <= {hist_r[29:0], rx_bit};
      fill_r    <= (fill_r == lst_pkg::LST_CHK_FILL) ? fill_r
                                                      : fill_r + 5'h01;
      err_pulse <= (fill_r == lst_pkg::LST_CHK_FILL) &&
                   (rx_bit != expect_bit);
    end else begin
      fill_r    <= '0;
      err_pulse <= 1'b0;
    end
  end

endmodule : lst_pattern

/* File: logic/lst_ctrl.sv */
// loss indication routing and test pattern control with apb registers
`timescale 1ns/1ns
module lst_ctrl (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  // lane condition pins
  input  wire logic [12:0] lane_cond_in,
  // fast side serial data
  input  wire logic        fast_data_in,
  output logic             fast_tx_bit,
  input  wire logic        fast_rx_bit,
  // slow side serial data
  input  wire logic        slow_data_in,
  output logic             slow_tx_bit,
  input  wire logic        slow_rx_bit,
  // indication outputs
  output logic             channel_loss_indication_pin,
  output logic             irq
);

  // ************************************************************
  // registers and wires
  // ************************************************************
  logic [15:0]            overlay_r;
  logic [15:0]            patctrl_r;
  logic [15:0]            fast_side_error_counter;
  logic [15:0]            slow_err_cnt_r;
  logic [2:0]             irq_stat_r;
  logic [2:0]             irq_mask_r;
  lst_pkg::lst_mode_t     mode_r;
  lst_pkg::lst_cond_t     cond;
  logic [12:0]            cond_raw;
  logic                   wr_en;
  logic                   rd_en;
  logic [5:0]             idx;
  logic                   addr_ok;
  logic                   loss_now;
  logic                   pin_rise;
  logic [2:0]             irq_set;
  logic [2:0]             slow_pattern_select;
  logic [2:0]             fast_pattern_select;
  logic                   fast_ok;
  logic                   slow_ok;
  logic                   fast_pat;
  logic                   slow_pat;
  logic                   fast_err;
  logic                   slow_err;
  logic [31:0]            rd_mux;

  // merge write data into a 16-bit register under byte strobes
  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
    wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : wmerge

  // ************************************************************
  // input synchronisation
  // ************************************************************
  lst_sync #(.W(13)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (lane_cond_in),
    .sync_out (cond_raw)
  );
  assign cond = cond_raw;

  // ************************************************************
  // apb slave: one wait-free access cycle after setup
  // ************************************************************
  assign idx     = paddr[7:2];
  assign addr_ok = (paddr[1:0] == 2'h0) &&
                   (idx == lst_pkg::LST_IDX_OVERLAY  ||
                    idx == lst_pkg::LST_IDX_PATCTRL  ||
                    idx == lst_pkg::LST_IDX_FAST_ERR ||
                    idx == lst_pkg::LST_IDX_SLOW_ERR ||
                    idx == lst_pkg::LST_IDX_IRQ_STAT ||
                    idx == lst_pkg::LST_IDX_IRQ_MASK ||
                    idx == lst_pkg::LST_IDX_MODE);
  assign wr_en = psel & penable & pready & pwrite & addr_ok;
  assign rd_en = psel & ~penable & ~pwrite;

  // read data mux; unmapped words read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      lst_pkg::LST_IDX_OVERLAY:  rd_mux[15:0] = overlay_r;
      lst_pkg::LST_IDX_PATCTRL:  rd_mux[15:0] = patctrl_r;
      lst_pkg::LST_IDX_FAST_ERR: rd_mux[15:0] = fast_side_error_counter;
      lst_pkg::LST_IDX_SLOW_ERR: rd_mux[15:0] = slow_err_cnt_r;
      lst_pkg::LST_IDX_IRQ_STAT: rd_mux[2:0]  = irq_stat_r;
      lst_pkg::LST_IDX_IRQ_MASK: rd_mux[2:0]  = irq_mask_r;
      lst_pkg::LST_IDX_MODE:     rd_mux[1:0]  = mode_r;
      default:                   rd_mux       = 32'h0000_0000;
    endcase
  end

  // ready, read data and error are set up in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (rd_en && addr_ok) begin
        prdata <= rd_mux;
      end else if (psel && !penable) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ************************************************************
  // control registers
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overlay_r <= lst_pkg::LST_OVERLAY_RST;
      patctrl_r <= lst_pkg::LST_PATCTRL_RST;
    end else if (wr_en && idx == lst_pkg::LST_IDX_OVERLAY) begin
      overlay_r <= wmerge(overlay_r, pwdata, pstrb);
    end else if (wr_en && idx == lst_pkg::LST_IDX_PATCTRL) begin
      patctrl_r <= wmerge(patctrl_r, pwdata, pstrb);
    end
  end

  // operating mode; the unused code is refused and the mode kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= lst_pkg::LST_MODE_1GKX;
    end else if (wr_en && idx == lst_pkg::LST_IDX_MODE && pstrb[0] &&
                 pwdata[1:0] != 2'h3) begin
      mode_r <= lst_pkg::lst_mode_t'(pwdata[1:0]);
    end
  end

  // ************************************************************
  // loss indication pin
  // ************************************************************
  assign loss_now =
      |(overlay_r[lst_pkg::LST_POS_SYNC_LO +: 4] & cond.sync_loss) |
      |(overlay_r[lst_pkg::LST_POS_CODE_LO +: 4] & cond.bad_code)  |
      |(overlay_r[lst_pkg::LST_POS_SIG_LO +: 4] & cond.signal_loss) |
      (overlay_r[lst_pkg::LST_POS_PLL_EN] & cond.pll_unlock);

  // pin is the or of all enabled conditions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_loss_indication_pin <= 1'b0;
    end else begin
      channel_loss_indication_pin <= loss_now;
    end
  end

  // ************************************************************
  // test pattern selection and engines
  // ************************************************************
  assign fast_pattern_select = patctrl_r[lst_pkg::LST_POS_FSEL_LO +: 3];
  assign slow_pattern_select = {patctrl_r[lst_pkg::LST_POS_SSEL_HI],
                                patctrl_r[lst_pkg::LST_POS_SSEL_LO +: 2]};
  // periodic fast codes only outside 10G-KR; prbs everywhere
  assign fast_ok = (fast_pattern_select >= lst_pkg::LST_PAT_PRBS7) ||
                   (mode_r != lst_pkg::LST_MODE_10GKR);
  // crpat on the slow side only in 1G-KX
  assign slow_ok = !(slow_pattern_select == lst_pkg::LST_PAT_CRL ||
                     slow_pattern_select == lst_pkg::LST_PAT_CRS) ||
                   (mode_r == lst_pkg::LST_MODE_1GKX);

  lst_pattern u_fast (
    .pclk      (pclk),
    .presetn   (presetn),
    .gen_en    (patctrl_r[lst_pkg::LST_POS_FGEN]),
    .chk_en    (patctrl_r[lst_pkg::LST_POS_FCHK]),
    .sel       (fast_pattern_select),
    .sel_ok    (fast_ok),
    .pat_bit   (fast_pat),
    .rx_bit    (fast_rx_bit),
    .err_pulse (fast_err)
  );

  lst_pattern u_slow (
    .pclk      (pclk),
    .presetn   (presetn),
    .gen_en    (patctrl_r[lst_pkg::LST_POS_SGEN]),
    .chk_en    (patctrl_r[lst_pkg::LST_POS_SCHK]),
    .sel       (slow_pattern_select),
    .sel_ok    (slow_ok),
    .pat_bit   (slow_pat),
    .rx_bit    (slow_rx_bit),
    .err_pulse (slow_err)
  );

  // transmit mux: pattern while generating, normal data otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_tx_bit <= 1'b0;
      slow_tx_bit <= 1'b0;
    end else begin
      fast_tx_bit <= patctrl_r[lst_pkg::LST_POS_FGEN] ? fast_pat
                                                       : fast_data_in;
      slow_tx_bit <= patctrl_r[lst_pkg::LST_POS_SGEN] ? slow_pat
                                                       : slow_data_in;
    end
  end

  // ************************************************************
  // error counters: saturate, any write clears, an error wins
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_side_error_counter <= 16'h0000;
    end else if (wr_en && idx == lst_pkg::LST_IDX_FAST_ERR) begin
      fast_side_error_counter <= {15'h0000, fast_err};
    end else if (fast_err &&
                 fast_side_error_counter != lst_pkg::LST_ERR_MAX) begin
      fast_side_error_counter <= fast_side_error_counter + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_err_cnt_r <= 16'h0000;
    end else if (wr_en && idx == lst_pkg::LST_IDX_SLOW_ERR) begin
      slow_err_cnt_r <= {15'h0000, slow_err};
    end else if (slow_err && slow_err_cnt_r != lst_pkg::LST_ERR_MAX) begin
      slow_err_cnt_r <= slow_err_cnt_r + 16'h0001;
    end
  end

  // ************************************************************
  // interrupts: sticky status, write one to clear, set wins
  // ************************************************************
  assign pin_rise = loss_now & ~channel_loss_indication_pin;
  assign irq_set  = {slow_err, fast_err, pin_rise};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= 3'h0;
    end else if (wr_en && idx == lst_pkg::LST_IDX_IRQ_STAT && pstrb[0]) begin
      irq_stat_r <= (irq_stat_r & ~pwdata[2:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= 3'h0;
    end else if (wr_en && idx == lst_pkg::LST_IDX_IRQ_MASK && pstrb[0]) begin
      irq_mask_r <= pwdata[2:0];
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sync_loss_pin: assert property (
    |(overlay_r[11:8] & cond.sync_loss) |=> channel_loss_indication_pin)
    else $error("enabled sync loss did not raise loss pin");
  a_bad_code_pin: assert property (
    |(overlay_r[7:4] & cond.bad_code) |=> channel_loss_indication_pin)
    else $error("enabled invalid code did not raise loss pin");
  a_sig_loss_pin: assert property (
    |(overlay_r[3:0] & cond.signal_loss) |=> channel_loss_indication_pin)
    else $error("enabled signal loss did not raise loss pin");
  a_pll_unlock_pin: assert property (
    overlay_r[12] && cond.pll_unlock |=> channel_loss_indication_pin)
    else $error("enabled pll unlock did not raise loss pin");
  a_pin_quiet_off: assert property (
    overlay_r[12:0] == 13'h0000 |=> !channel_loss_indication_pin)
    else $error("loss pin high with all enables clear");
  a_fast_tx_normal: assert property (
    !patctrl_r[13] |=> fast_tx_bit == $past(fast_data_in))
    else $error("fast side not passing normal data");
  a_slow_tx_normal: assert property (
    !patctrl_r[7] |=> slow_tx_bit == $past(slow_data_in))
    else $error("slow side not passing normal data");
  a_fast_chk_quiet: assert property (
    !patctrl_r[12] ##1 !patctrl_r[12] |-> !fast_err)
    else $error("fast checker reports with checking off");
  a_kr_periodic_off: assert property (
    mode_r == lst_pkg::LST_MODE_10GKR && fast_pattern_select < 3'h5
    |-> !fast_ok)
    else $error("periodic fast pattern accepted in 10G-KR");
  a_fast_err_count: assert property (
    fast_err && fast_side_error_counter < 16'hFFFE && !wr_en
    |=> fast_side_error_counter == $past(fast_side_error_counter) + 16'h1)
    else $error("fast error not counted");
  a_apb_one_wait: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("apb ready not a single cycle");

  c_loss_pin_up: cover property (!channel_loss_indication_pin
                                 ##1 channel_loss_indication_pin);
  c_fast_error: cover property (fast_err);
  c_irq_raised: cover property (!irq ##1 irq);
  c_slow_gen_on: cover property (patctrl_r[7] && slow_ok);

endmodule : lst_ctrl

/* File: tb/lst_link_partner.sv */
// far-side lane model that returns each serial bit one cycle later
`timescale 1ns/1ns
module lst_link_partner (
  // clock
  input  wire logic pclk,
  // error injection
  input  wire logic corrupt,
  // serial lines
  input  wire logic fast_tx_bit,
  input  wire logic slow_tx_bit,
  output logic      fast_rx_bit,
  output logic      slow_rx_bit
);
  // ****
  // loopback
  // ****
  // corrupt flips returned bits so the checkers see real mismatches
  always_ff @(posedge pclk) begin
    fast_rx_bit <= fast_tx_bit ^ corrupt;
    slow_rx_bit <= slow_tx_bit ^ corrupt;
  end
endmodule : lst_link_partner

/* File: tb/testbench.sv */
// self-checking bench for the loss indication and pattern control block
`timescale 1ns/1ns
module testbench;
  logic        pclk, presetn, psel, penable, pwrite, corrupt, pready;
  logic        pslverr, fast_in, slow_in, f_tx, s_tx, f_rx, s_rx, pin, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [12:0] cond, en;
  logic [1:0]  d_tx;
  logic [15:0] pc;
  logic [30:0] fh, sh;
  logic [32:0] exp_q[$];
  int          seed, n_mismatch, num_checks, i;

  lst_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .lane_cond_in(cond), .fast_data_in(fast_in), .fast_tx_bit(f_tx),
    .fast_rx_bit(f_rx), .slow_data_in(slow_in), .slow_tx_bit(s_tx),
    .slow_rx_bit(s_rx), .channel_loss_indication_pin(pin), .irq(irq));
  lst_link_partner u_far (.pclk(pclk), .corrupt(corrupt),
    .fast_tx_bit(f_tx), .slow_tx_bit(s_tx), .fast_rx_bit(f_rx),
    .slow_rx_bit(s_rx));

  // ****
  // clock, data and result watcher
  // ****
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // random normal data and a copy of what the tx bits should echo
  always @(posedge pclk) begin
    fast_in <= 1'($random(seed));
    slow_in <= 1'($random(seed));
    d_tx <= {fast_in, slow_in};
    fh <= {fh[29:0], f_tx};
    sh <= {sh[29:0], s_tx};
  end
  // read results are matched against the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      cmp(exp_q.pop_front(), {pslverr, prdata});
    end
  end

  task automatic cmp(input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp

  task automatic apb(input logic w, input logic [5:0] a,
                     input logic [15:0] d, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'h0};
    pwdata <= {16'h0, d};
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic later;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
  endtask : later

  // next bit of pattern code k from the bits sent before it
  function automatic logic nxt(input int k, input logic [30:0] h);
    case (k)
      0: nxt = h[1];
      1: nxt = h[9];
      5: nxt = h[6] ^ h[5];
      6: nxt = h[22] ^ h[17];
      7: nxt = h[30] ^ h[27];
      default: nxt = h[19];
    endcase
  endfunction : nxt

  task automatic pin_chk(input logic [12:0] c);
    @(posedge pclk);
    cond <= c;
    later;
    cmp({32'h0, |(en & c)}, {32'h0, pin});
  endtask : pin_chk

  task automatic close_out;
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out

  // watchdog against a hung handshake
  initial begin
    #200000;
    n_mismatch++;
    close_out;
  end

  // ****
  // main sequence
  // ****
  initial begin
    {presetn, psel, penable, pwrite, corrupt} = 5'h0;
    {cond, en, paddr, pwdata} = '0;
    seed = 85889;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, lst_pkg::LST_IDX_OVERLAY, 16'h0,
        {17'h0, lst_pkg::LST_OVERLAY_RST});
    apb(1'b0, lst_pkg::LST_IDX_PATCTRL, 16'h0,
        {17'h0, lst_pkg::LST_PATCTRL_RST});
    apb(1'b0, 6'h3F, 16'h0, {1'b1, 32'h0});
    for (i = 0; i < 16; i++) begin
      @(negedge pclk);
      cmp({31'h0, d_tx}, {31'h0, f_tx, s_tx});
    end
    for (i = 0; i < 26; i++) begin
      en = (i < 13) ? 13'h1 << i : 13'($random(seed));
      apb(1'b1, lst_pkg::LST_IDX_OVERLAY, {3'h0, en}, 33'h0);
      apb(1'b0, lst_pkg::LST_IDX_OVERLAY, 16'h0, {20'h0, en});
      pin_chk(13'($random(seed)) & ~en);
      pin_chk(13'($random(seed)) | en);
    end
    apb(1'b1, 6'h23, 16'h1, 33'h0);
    later;
    cmp(33'h1, {32'h0, irq});
    pin_chk(13'h0);
    apb(1'b1, 6'h22, 16'h7, 33'h0);
    apb(1'b0, 6'h22, 16'h0, 33'h0);
    later;
    cmp(33'h0, {32'h0, irq});
    // invalid selects for the mode keep both lines low
    apb(1'b1, 6'h24, 16'h2, 33'h0);
    apb(1'b1, lst_pkg::LST_IDX_PATCTRL, 16'h20B0, 33'h0);
    for (i = 0; i < 8; i++) begin
      later;
      cmp(33'h0, {31'h0, f_tx, s_tx});
    end
    // 10G keeps fast periodic data but refuses slow crpat and mode 3
    apb(1'b1, 6'h24, 16'h1, 33'h0);
    apb(1'b1, 6'h24, 16'h3, 33'h0);
    apb(1'b0, 6'h24, 16'h0, 33'h1);
    later;
    cmp({32'h0, ~fh[0]}, {32'h0, f_tx});
    cmp(33'h0, {32'h0, s_tx});
    apb(1'b1, 6'h24, 16'h0, 33'h0);
    for (i = 0; i < 8; i++) begin
      pc = {2'h0, 2'h2, i[2], i[2:0], 2'h2, i[1:0], 4'h0};
      apb(1'b1, lst_pkg::LST_IDX_PATCTRL, pc, 33'h0);
      repeat (40) @(posedge pclk);
      // sent streams must follow the selected pattern bit by bit
      repeat (8) begin
        @(negedge pclk);
        cmp({31'h0, nxt(i, fh), nxt(i, sh)},
            {31'h0, f_tx, s_tx});
      end
      cmp(33'h3, {31'h0, |fh, |sh});
      apb(1'b1, lst_pkg::LST_IDX_PATCTRL, pc | 16'h1040, 33'h0);
      repeat (80) @(posedge pclk);
      apb(1'b1, 6'h20, 16'h0, 33'h0);
      apb(1'b1, 6'h21, 16'h0, 33'h0);
      repeat (60) @(posedge pclk);
      apb(1'b0, 6'h20, 16'h0, 33'h0);
      apb(1'b0, 6'h21, 16'h0, 33'h0);
      apb(1'b0, lst_pkg::LST_IDX_PATCTRL, 16'h0, {17'h0, pc | 16'h1040});
    end
    // one corrupted bit must be seen by both checkers
    apb(1'b1, 6'h22, 16'h7, 33'h0);
    apb(1'b1, 6'h23, 16'h6, 33'h0);
    corrupt <= 1'b1;
    @(posedge pclk);
    corrupt <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(1'b0, 6'h22, 16'h0, 33'h6);
    apb(1'b0, 6'h20, 16'h0, 33'h3);
    apb(1'b0, 6'h21, 16'h0, 33'h3);
    later;
    cmp(33'h1, {32'h0, irq});
    apb(1'b1, 6'h22, 16'h6, 33'h0);
    later;
    cmp(33'h0, {32'h0, irq});
    close_out;
  end
endmodule : testbench
